// ### detector_status_byte_packer.v
// Additional status byte packer and self test descriptor selector
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
`include "status_packer_regs.vh"

module detector_status_byte_packer (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // Reply request from the command layer
    input  wire        req_valid_i,
    input  wire [7:0]  req_cmd_i,
    input  wire [2:0]  byte_index_i,
    // Condition flags, same clock domain
    input  wire        unit_is_receiver_i,
    input  wire [1:0]  beam_block_i,
    input  wire        low_light_i,
    input  wire        over_temp_i,
    input  wire        under_temp_i,
    input  wire        wireless_configured_i,
    input  wire        heater_on_i,
    input  wire [3:0]  calib_valid_primary_i,
    input  wire [1:0]  signal_loss_suppr_i,
    input  wire [1:0]  fp_fail_primary_i,
    input  wire [1:0]  lock_primary_i,
    input  wire [1:0]  lock_fail_primary_i,
    input  wire [1:0]  negative_gas_i,
    input  wire        diffuser_fail_i,
    input  wire        no_optical_link_packets_i,
    input  wire [1:0]  lock_secondary_i,
    input  wire [1:0]  lock_fail_secondary_i,
    input  wire [1:0]  zero_valid_secondary_i,
    input  wire [1:0]  span_valid_secondary_i,
    input  wire [1:0]  fp_fail_secondary_i,
    // Self test completion event
    input  wire        selftest_done_i,
    input  wire [1:0]  selftest_outcome_i,
    input  wire [16:0] selftest_value_i,
    input  wire [23:0] selftest_date_i,
    // Status byte reply
    output reg         status_valid_o,
    output reg  [7:0]  status_byte_o,
    // Descriptor reply
    output reg         desc_valid_o,
    output reg  [1:0]  desc_msg_o,
    output reg  [16:0] desc_value_o,
    output reg  [23:0] desc_date_o,
    // Bookkeeping
    output wire        selftest_last_pass_o,
    output wire [16:0] selftest_value_o
);

    // ****************************************
    // Live status bytes
    // ****************************************
    wire [7:0] status_general;
    wire [7:0] status_calib_primary;
    wire [7:0] status_lock_primary;
    wire [7:0] status_lock_secondary;
    wire [7:0] status_fingerprint_secondary;

    assign status_general = {unit_is_receiver_i, beam_block_i[0], beam_block_i[1],
                             low_light_i, over_temp_i, under_temp_i,
                             wireless_configured_i, heater_on_i};
    assign status_calib_primary = {calib_valid_primary_i,
                                   signal_loss_suppr_i[0], signal_loss_suppr_i[1],
                                   fp_fail_primary_i[0], fp_fail_primary_i[1]};
    assign status_lock_primary = {lock_primary_i[0], lock_primary_i[1],
                                  lock_fail_primary_i[0], lock_fail_primary_i[1],
                                  negative_gas_i[0], negative_gas_i[1],
                                  diffuser_fail_i, no_optical_link_packets_i};
    assign status_lock_secondary = {lock_secondary_i[0], lock_secondary_i[1],
                                    lock_fail_secondary_i[0], lock_fail_secondary_i[1],
                                    zero_valid_secondary_i[0], zero_valid_secondary_i[1],
                                    span_valid_secondary_i[0], span_valid_secondary_i[1]};
    // Low six bits unassigned, held at zero
    assign status_fingerprint_secondary = {fp_fail_secondary_i[0], fp_fail_secondary_i[1],
                                           6'h00};

    // ****************************************
    // Byte select
    // ****************************************
    reg [7:0] status_byte_next;

    always @* begin
        if (byte_index_i == `OFS_STATUS_GENERAL) begin
            status_byte_next = status_general;
        end else if (byte_index_i == `OFS_STATUS_CALIB_PRIMARY) begin
            status_byte_next = status_calib_primary;
        end else if (byte_index_i == `OFS_STATUS_LOCK_PRIMARY) begin
            status_byte_next = status_lock_primary;
        end else if (byte_index_i == `OFS_STATUS_LOCK_SECONDARY) begin
            status_byte_next = status_lock_secondary;
        end else if (byte_index_i == `OFS_STATUS_FINGERPRINT_SECONDARY) begin
            status_byte_next = status_fingerprint_secondary;
        end else begin
            status_byte_next = 8'h00;
        end
    end

    // ****************************************
    // Stored self test result
    // ****************************************
    // Held here because the descriptor must survive after the test ends
    reg [1:0]  outcome_reg;
    reg [16:0] value_reg;
    reg [23:0] date_reg;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            outcome_reg <= `SELFTEST_NONE;
            value_reg   <= `VALUE_RESET;
            date_reg    <= `DATE_RESET;
        end else if (selftest_done_i && selftest_outcome_i != `SELFTEST_NONE) begin
            outcome_reg <= selftest_outcome_i;
            value_reg   <= selftest_value_i;
            date_reg    <= selftest_date_i;
        end
    end

    // High background is a pass for bookkeeping
    assign selftest_last_pass_o = (outcome_reg == `SELFTEST_PASS) ||
                                  (outcome_reg == `SELFTEST_HIGH_BACKGROUND);
    assign selftest_value_o = value_reg;

    // ****************************************
    // Message select
    // ****************************************
    reg [1:0] desc_msg_next;

    always @* begin
        case (outcome_reg)
            `SELFTEST_FAIL: begin
                desc_msg_next = `MSG_SELFTEST_FAIL;
            end
            `SELFTEST_PASS: begin
                desc_msg_next = `MSG_SELFTEST_PASS;
            end
            `SELFTEST_HIGH_BACKGROUND: begin
                desc_msg_next = `MSG_SELFTEST_HIGH_BACKGROUND;
            end
            default: begin
                desc_msg_next = `MSG_NONE;
            end
        endcase
    end

    // ****************************************
    // Reply registers
    // ****************************************
    // Flags sampled on the request edge, not latched earlier
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_valid_o <= 1'b0;
            status_byte_o  <= 8'h00;
            desc_valid_o   <= 1'b0;
            desc_msg_o     <= `MSG_NONE;
            desc_value_o   <= `VALUE_RESET;
            desc_date_o    <= `DATE_RESET;
        end else begin
            status_valid_o <= req_valid_i && req_cmd_i == `CMD_READ_ADDITIONAL_STATUS;
            desc_valid_o   <= req_valid_i && req_cmd_i == `CMD_READ_TAG_DESC_DATE;
            if (req_valid_i && req_cmd_i == `CMD_READ_ADDITIONAL_STATUS) begin
                status_byte_o <= status_byte_next;
            end
            if (req_valid_i && req_cmd_i == `CMD_READ_TAG_DESC_DATE) begin
                desc_msg_o   <= desc_msg_next;
                desc_value_o <= value_reg;
                desc_date_o  <= date_reg;
            end
        end
    end

endmodule // detector_status_byte_packer

`default_nettype wire

// ### status_packer_regs.vh
// Offsets, field positions, command codes and message codes of the status byte packer
`ifndef STATUS_PACKER_REGS_VH
`define STATUS_PACKER_REGS_VH

// ****************************************
// Status byte offsets
// ****************************************
`define OFS_STATUS_GENERAL              3'h0
`define OFS_STATUS_CALIB_PRIMARY        3'h1
`define OFS_STATUS_LOCK_PRIMARY         3'h2
`define OFS_STATUS_LOCK_SECONDARY       3'h3
`define OFS_STATUS_FINGERPRINT_SECONDARY 3'h4
`define STATUS_BYTE_COUNT               3'h5

// ****************************************
// Command codes
// ****************************************
`define CMD_READ_TAG_DESC_DATE          8'h0D
`define CMD_READ_ADDITIONAL_STATUS      8'h30

// ****************************************
// Status byte 0 field positions
// ****************************************
`define B0_UNIT_TYPE                    7
`define B0_BEAM_BLOCK_FIRST             6
`define B0_BEAM_BLOCK_SECOND            5
`define B0_LOW_LIGHT                    4
`define B0_OVER_TEMP                    3
`define B0_UNDER_TEMP                   2
`define B0_WIRELESS_CONFIGURED          1
`define B0_HEATER_ON                    0

// ****************************************
// Self test outcome and message codes
// ****************************************
`define SELFTEST_NONE                   2'h0
`define SELFTEST_FAIL                   2'h1
`define SELFTEST_PASS                   2'h2
`define SELFTEST_HIGH_BACKGROUND        2'h3
`define MSG_NONE                        2'h0
`define MSG_SELFTEST_FAIL               2'h1
`define MSG_SELFTEST_PASS               2'h2
`define MSG_SELFTEST_HIGH_BACKGROUND    2'h3

// ****************************************
// Reset values
// ****************************************
`define VALUE_RESET                     17'h00000
`define DATE_RESET                      24'h000000

`endif

// ### status_packer_checker.sv
// Concurrent checks on the status byte packer ports
`timescale 1ns/1ps
`default_nettype none
module status_packer_checker (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Requests and conditions
    input wire logic        req_valid_i,
    input wire logic [7:0]  req_cmd_i,
    input wire logic [2:0]  byte_index_i,
    input wire logic        unit_is_receiver_i,
    input wire logic        selftest_done_i,
    input wire logic [1:0]  selftest_outcome_i,
    // Replies
    input wire logic        status_valid_o,
    input wire logic [7:0]  status_byte_o,
    input wire logic        desc_valid_o,
    input wire logic        selftest_last_pass_o,
    input wire logic [16:0] selftest_value_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // Reply timing and contents
    // ****************************************
    wire st_req = req_valid_i && req_cmd_i == 8'h30;
    wire ds_req = req_valid_i && req_cmd_i == 8'h0D;
    stat_reply_a: assert property (st_req |=> status_valid_o) else $error("status reply missing");
    stat_cause_a: assert property (status_valid_o |-> $past(st_req)) else $error("status reply uncalled");
    desc_reply_a: assert property (ds_req |=> desc_valid_o) else $error("descriptor reply missing");
    desc_cause_a: assert property (desc_valid_o |-> $past(ds_req)) else $error("descriptor reply uncalled");
    unit_bit_a: assert property (st_req && byte_index_i == 3'h0 |=> status_byte_o[7] == $past(unit_is_receiver_i))
        else $error("unit type bit wrong");
    spare_bits_a: assert property (status_valid_o && $past(byte_index_i) == 3'h4 |-> status_byte_o[5:0] == 6'h00)
        else $error("unused bits set");
    spare_bytes_a: assert property (status_valid_o && $past(byte_index_i) > 3'h4 |-> status_byte_o == 8'h00)
        else $error("unused byte set");
    hibg_pass_a: assert property (selftest_done_i && selftest_outcome_i == 2'h3 |=> selftest_last_pass_o)
        else $error("high background not a pass");
    fail_book_a: assert property (selftest_done_i && selftest_outcome_i == 2'h1 |=> !selftest_last_pass_o)
        else $error("failure booked as pass");
    value_hold_a: assert property (!selftest_done_i |=> $stable(selftest_value_o)) else $error("value moved");
    cover property (st_req && byte_index_i == 3'h4);
    cover property (ds_req);
    cover property (selftest_done_i && selftest_outcome_i == 2'h3);
endmodule // status_packer_checker
`default_nettype wire

// ### loop_master_model.sv
// Loop master model issuing reply requests to the status packer
`timescale 1ns/1ps
`default_nettype none
module loop_master_model (
    // Clock
    input  wire logic  clock_i,
    // Requests
    output logic       req_valid_o,
    output logic [7:0] req_cmd_o,
    output logic [2:0] byte_index_o
);
    initial begin
        req_valid_o = 1'b0;
        req_cmd_o = 8'hFF;
        byte_index_o = 3'h7;
    end
    // Released lines show the inverse so a stale value never passes
    task automatic ask(input logic [7:0] cmd, input logic [2:0] idx);
        @(posedge clock_i);
        #1;
        req_valid_o = 1'b1;
        req_cmd_o = cmd;
        byte_index_o = idx;
        @(posedge clock_i);
        #1;
        req_valid_o = 1'b0;
        req_cmd_o = ~cmd;
        byte_index_o = ~idx;
    endtask
endmodule // loop_master_model
`default_nettype wire

// ### detector_status_byte_packer_tb_top.sv
// Self-checking bench for the detector status byte packer
`timescale 1ns/1ps
`default_nettype none
module detector_status_byte_packer_tb_top;
    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [63:0] f = 64'h0;
    logic        done = 1'b0;
    logic [1:0]  outc = 2'h0;
    logic [16:0] val = 17'h00000;
    logic [23:0] date = 24'h000000;
    wire         rv, sv, dv, lp;
    wire  [7:0]  cmd, sb;
    wire  [2:0]  idx;
    wire  [1:0]  msg;
    wire  [16:0] dval, sval;
    wire  [23:0] ddate;
    int          mismatches = 0;
    int          tests_run = 0;
    always #50 clock_i = ~clock_i;
    loop_master_model m (.clock_i(clock_i), .req_valid_o(rv), .req_cmd_o(cmd), .byte_index_o(idx));
    // Flag vector laid out so that byte k reads back as f[8k+7:8k]
    detector_status_byte_packer dut (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(rv), .req_cmd_i(cmd),
        .byte_index_i(idx), .unit_is_receiver_i(f[7]), .beam_block_i({f[5], f[6]}), .low_light_i(f[4]),
        .over_temp_i(f[3]), .under_temp_i(f[2]), .wireless_configured_i(f[1]), .heater_on_i(f[0]),
        .calib_valid_primary_i(f[15:12]), .signal_loss_suppr_i({f[10], f[11]}), .fp_fail_primary_i({f[8], f[9]}),
        .lock_primary_i({f[22], f[23]}), .lock_fail_primary_i({f[20], f[21]}), .negative_gas_i({f[18], f[19]}),
        .diffuser_fail_i(f[17]), .no_optical_link_packets_i(f[16]), .lock_secondary_i({f[30], f[31]}),
        .lock_fail_secondary_i({f[28], f[29]}), .zero_valid_secondary_i({f[26], f[27]}),
        .span_valid_secondary_i({f[24], f[25]}), .fp_fail_secondary_i({f[38], f[39]}),
        .selftest_done_i(done), .selftest_outcome_i(outc), .selftest_value_i(val), .selftest_date_i(date),
        .status_valid_o(sv), .status_byte_o(sb), .desc_valid_o(dv), .desc_msg_o(msg), .desc_value_o(dval),
        .desc_date_o(ddate), .selftest_last_pass_o(lp), .selftest_value_o(sval));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic selftest(input logic [1:0] o, input logic [16:0] v, input logic [23:0] d);
        @(posedge clock_i);
        #1;
        done = 1'b1;
        outc = o;
        val = v;
        date = d;
        @(posedge clock_i);
        #1;
        done = 1'b0;
    endtask
    task automatic chk_desc(input logic [1:0] o, input logic [16:0] v, input logic [23:0] d);
        m.ask(8'h0D, 3'h0);
        check(dv, 1);
        check(msg, o);
        check(dval, v);
        check(ddate, d);
        check(sval, v);
        check(lp, o[1]);
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        chk_desc(2'h0, 17'h00000, 24'h000000);
        selftest(2'h1, 17'h1869F, 24'h0A0B0C);
        chk_desc(2'h1, 17'h1869F, 24'h0A0B0C);
        selftest(2'h2, 17'h00005, 24'h010203);
        chk_desc(2'h2, 17'h00005, 24'h010203);
        selftest(2'h0, 17'h00777, 24'hFFFFFF);
        chk_desc(2'h2, 17'h00005, 24'h010203);
        selftest(2'h3, 17'h00300, 24'h112233);
        chk_desc(2'h3, 17'h00300, 24'h112233);
        m.ask(8'h01, 3'h0);
        check(sv | dv, 0);
        // Walking one over every flag, then all flags at once
        for (int b = 0; b < 35; b++) begin
            f = (b == 34) ? 64'h000000C0FFFFFFFF : 64'h1 << (b < 32 ? b : b + 6);
            for (int i = 0; i < 8; i++) begin
                m.ask(8'h30, i[2:0]);
                check(sv, 1);
                check(sb, f[8 * i +: 8]);
            end
        end
        tally_and_finish;
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish;
    end
endmodule // detector_status_byte_packer_tb_top
bind detector_status_byte_packer status_packer_checker chk (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .byte_index_i(byte_index_i),
    .unit_is_receiver_i(unit_is_receiver_i), .selftest_done_i(selftest_done_i),
    .selftest_outcome_i(selftest_outcome_i), .status_valid_o(status_valid_o), .status_byte_o(status_byte_o),
    .desc_valid_o(desc_valid_o), .selftest_last_pass_o(selftest_last_pass_o), .selftest_value_o(selftest_value_o));
`default_nettype wire
